/* File: pkg/icf_pkg.sv */
/*
  Shared constants and carrier types for the interrupt control and flag
  register block: register offsets, bit positions, masks and reset values.
  Assumes a 32-bit AXI4-Lite bus with byte addresses on 8 low bits.
*/
package icf_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CORE  = 8'h00;
  localparam logic [7:0] OFF_GCTL  = 8'h04;
  localparam logic [7:0] OFF_EVCTL = 8'h08;
  localparam logic [7:0] OFF_FLO   = 8'h0C;
  localparam logic [7:0] OFF_FNX   = 8'h10;
  localparam logic [7:0] OFF_PRIO  = 8'h14;

  // Bit positions inside the registers.
  localparam int BIT_PL_MSB = 3;
  localparam int BIT_VIS    = 2;
  localparam int BIT_NEST   = 15;
  localparam int BIT_ARITH  = 4;
  localparam int BIT_ADDR   = 3;
  localparam int BIT_STACK  = 2;
  localparam int BIT_OSC    = 1;
  localparam int BIT_ALTV   = 15;
  localparam int BIT_TBLK   = 14;
  localparam int PRIO_LSB   = 5;
  localparam int EXT0_BIT   = 0;
  localparam int EXT1_BIT   = 4;
  localparam int EXT2_BIT   = 13;
  localparam int NUM_EXT    = 5;

  // Implemented-bit masks; all other positions read zero, except edge control bit 14 (timed block).
  localparam logic [15:0] MASK_GCTL  = 16'h801E;
  localparam logic [15:0] MASK_EVSW  = 16'h801F;
  localparam logic [15:0] MASK_FLO   = 16'h7FFF;
  localparam logic [15:0] MASK_FNX   = 16'hFF1F;

  // Reset values.
  localparam logic [15:0] RST_CORE   = 16'h0004;
  localparam logic [15:0] RST_ZERO   = 16'h0000;
  localparam logic [2:0]  PRIO_ALL1  = 3'h7;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Trap events raised by the core, one-cycle pulses.
  typedef struct packed {
    logic arith;
    logic addr;
    logic stack;
    logic osc;
  } icf_trap_t;

  // Priority load from the core when it enters or leaves a handler.
  typedef struct packed {
    logic       load;
    logic [2:0] level;
  } icf_prio_load_t;

  // State presented to the core.
  typedef struct packed {
    logic [3:0] level;
    logic       user_blocked;
    logic       nesting_disable;
    logic       alt_vector;
  } icf_core_view_t;

endpackage

/* File: design/icf_ext_edge.sv */
/*
  Edge detector for the external interrupt pins. Each pin passes three
  flip-flops; a level counts once the second and third stages agree, and
  a change of that level in the selected direction gives a one-cycle pulse.
  Assumes the pins are asynchronous to aclk.
*/
`timescale 1ns/10ps
module icf_ext_edge
  import icf_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [NUM_EXT-1:0]  pin,
  input  wire logic [NUM_EXT-1:0]  neg_edge_sel,
  output logic      [NUM_EXT-1:0]  edge_pulse_q
);

  logic [NUM_EXT-1:0] s1_q;
  logic [NUM_EXT-1:0] s2_q;
  logic [NUM_EXT-1:0] s3_q;
  logic [NUM_EXT-1:0] level_q;

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : g_pin
      // Three-stage synchroniser; only the second stage reads the first.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end

      // Filtered level and edge pulse of the selected polarity.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          level_q[g]      <= 1'b0;
          edge_pulse_q[g] <= 1'b0;
        end else begin
          edge_pulse_q[g] <= 1'b0;
          if (s2_q[g] == s3_q[g]) begin
            level_q[g] <= s3_q[g];
            if (s3_q[g] != level_q[g] && s3_q[g] == !neg_edge_sel[g]) begin
              edge_pulse_q[g] <= 1'b1; // RL13
            end
          end
        end
      end
    end
  endgenerate

endmodule

/* File: design/icf_top.sv */
/*
  Interrupt control and request flag registers behind an AXI4-Lite slave:
  core priority control, global control with trap status, edge and vector
  control, two request flag registers and the processor priority field.
  Assumes the core and peripherals run on aclk and give one-cycle pulses.
*/
// Functional notes
// RL1 - Priority msb reads 1 when processor priority is above seven.
// RL2 - Full priority is msb placed above the three status priority bits.
// RL3 - Priority msb resets to 0, readable, software may only clear it.
// RL4 - Core control bit 2 resets to 1 and reads program space visibility.
// RL5 - Unimplemented bits read zero and ignore writes.
// RL6 - Global control bit 15 disables nesting when set, resets 0.
// RL7 - Global control bit 4 is arithmetic trap status, read/write.
// RL8 - Global control bit 3 is address trap status, read/write.
// RL9 - Global control bit 2 is stack trap status, read/write.
// RL10 - Global control bit 1 is oscillator fail trap status.
// RL11 - Edge control bit 15 selects the alternate vector table.
// RL12 - Edge control bit 14 shows timed interrupt block, read-only.
// RL13 - Edge control bits 4..0 pick negative (1) or positive edge.
// RL14 - Request flags are read/write, reset 0, show pending requests.
// RL15 - Low flags bits 14..8: dma1, adc, uart tx/rx, spi tx/gen, timer3.
// RL16 - Low flags bits 7..0: timer2, cmp2, cap2, dma0, timer1, cmp1, cap1, ext0.
// RL17 - Next flags bits 15..8: uart b tx/rx, ext2, t5, t4, cmp4, cmp3, dma2.
// RL18 - Next flags bits 4..0: ext1, change, comparator, i2c master, slave.
// RL19 - Sources set flags; only software clears them.
// RL20 - Priority field all ones blocks every user interrupt.
// RL21 - Priority field is read-only to software while nesting is off.
// RL22 - External pins synchronised; flag sets one clock after edge pulse.
`timescale 1ns/10ps
module icf_top
  import icf_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire icf_pkg::icf_trap_t   trap_evt,
  input  wire logic                 core_msb_set,
  input  wire icf_pkg::icf_prio_load_t prio_load,
  input  wire logic                 program_space_visibility,
  input  wire logic                 timed_block_in,
  input  wire logic [15:0]          src_evt_low,
  input  wire logic [15:0]          src_evt_next,
  input  wire logic [NUM_EXT-1:0]   ext_irq_pin,
  output icf_pkg::icf_core_view_t   core_view_q,
  output logic [NUM_EXT-1:0]        ext_edge_q
);

  logic        pl_msb_q;
  logic        vis_q;
  logic [15:0] gctl_q;
  logic [15:0] gctl_d;
  logic [15:0] evctl_q;
  logic [15:0] flo_q;
  logic [15:0] flo_d;
  logic [15:0] fnx_q;
  logic [15:0] fnx_d;
  logic [2:0]  prio_q;
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [15:0] wdata_q;
  logic [15:0] wmask_q;
  logic        w_have_q;
  logic        wr_en;
  logic        wr_ok;
  logic [15:0] rd_val;
  logic        rd_ok;
  logic [15:0] ext_low;
  logic [15:0] ext_next;

  // External pin edge detection.
  icf_ext_edge u_edge (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .pin          (ext_irq_pin),
    .neg_edge_sel (evctl_q[NUM_EXT-1:0]),
    .edge_pulse_q (ext_edge_q)
  );

  // Write commits once address and data are both held and no answer waits.
  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ok = (awaddr_q == OFF_CORE) || (awaddr_q == OFF_GCTL) ||
                 (awaddr_q == OFF_EVCTL) || (awaddr_q == OFF_FLO) ||
                 (awaddr_q == OFF_FNX) || (awaddr_q == OFF_PRIO);

  // Write address channel: taken in any order with the data channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_have_q     <= 1'b0;
      awaddr_q      <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_q     <= 1'b1;
      awaddr_q      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_have_q     <= 1'b0;
    end
  end

  // Write data channel; the two low byte lanes form the write mask.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_have_q     <= 1'b0;
      wdata_q      <= 16'h0000;
      wmask_q      <= 16'h0000;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_q     <= 1'b1;
      wdata_q      <= s_axi_wdata[15:0];
      wmask_q      <= {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_have_q     <= 1'b0;
    end
  end

  // Write response: one cycle after the commit, held until bready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Priority msb: set by the core on trap entry, software can only clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pl_msb_q <= RST_CORE[BIT_PL_MSB]; // RL3
    end else if (core_msb_set) begin
      pl_msb_q <= 1'b1; // RL1
    end else if (wr_en && awaddr_q == OFF_CORE && wmask_q[BIT_PL_MSB] &&
                 !wdata_q[BIT_PL_MSB]) begin
      pl_msb_q <= 1'b0; // RL3
    end
  end

  // Reserved bit mirrors program space visibility, one at reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vis_q <= RST_CORE[BIT_VIS]; // RL4
    end else begin
      vis_q <= program_space_visibility; // RL4
    end
  end

  // Global control: software writes merged, trap events win over a clear.
  always_comb begin
    gctl_d = gctl_q;
    if (wr_en && awaddr_q == OFF_GCTL) begin
      gctl_d = ((gctl_q & ~wmask_q) | (wdata_q & wmask_q)) & MASK_GCTL; // RL5
    end
    gctl_d[BIT_ARITH] = gctl_d[BIT_ARITH] | trap_evt.arith; // RL7
    gctl_d[BIT_ADDR]  = gctl_d[BIT_ADDR] | trap_evt.addr; // RL8
    gctl_d[BIT_STACK] = gctl_d[BIT_STACK] | trap_evt.stack; // RL9
    gctl_d[BIT_OSC]   = gctl_d[BIT_OSC] | trap_evt.osc; // RL10
  end

  // Global control register holding nesting disable and trap status.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gctl_q <= RST_ZERO; // RL6
    end else begin
      gctl_q <= gctl_d;
    end
  end

  // Edge and vector control; the timed-block bit follows the core only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evctl_q <= RST_ZERO; // RL11
    end else begin
      if (wr_en && awaddr_q == OFF_EVCTL) begin
        evctl_q[BIT_ALTV] <= wmask_q[BIT_ALTV] ? wdata_q[BIT_ALTV]
                                               : evctl_q[BIT_ALTV]; // RL11
        for (int i = 0; i < NUM_EXT; i++) begin
          if (wmask_q[i]) begin
            evctl_q[i] <= wdata_q[i]; // RL13
          end
        end
      end
      evctl_q[BIT_TBLK] <= timed_block_in; // RL12
    end
  end

  // Map the edge pulses of pins 0 to 2 onto their flag positions; pins 3 and 4 have no flag.
  always_comb begin
    ext_low            = 16'h0000;
    ext_next           = 16'h0000;
    ext_low[EXT0_BIT]  = ext_edge_q[0]; // RL22
    ext_next[EXT1_BIT] = ext_edge_q[1]; // RL22
    ext_next[EXT2_BIT] = ext_edge_q[2]; // RL22
  end

  // Request flags: software write merged, any source event wins the cycle.
  always_comb begin
    flo_d = flo_q;
    fnx_d = fnx_q;
    if (wr_en && awaddr_q == OFF_FLO) begin
      flo_d = (flo_q & ~wmask_q) | (wdata_q & wmask_q); // RL14
    end
    if (wr_en && awaddr_q == OFF_FNX) begin
      fnx_d = (fnx_q & ~wmask_q) | (wdata_q & wmask_q); // RL14
    end
    flo_d = (flo_d | src_evt_low | ext_low) & MASK_FLO; // RL15 RL16 RL19
    fnx_d = (fnx_d | src_evt_next | ext_next) & MASK_FNX; // RL17 RL18 RL19
  end

  // Flag registers, cleared at reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flo_q <= RST_ZERO; // RL14
      fnx_q <= RST_ZERO; // RL14
    end else begin
      flo_q <= flo_d;
      fnx_q <= fnx_d;
    end
  end

  // Priority field: core load first, software only while nesting allowed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_q <= 3'h0;
    end else if (prio_load.load) begin
      prio_q <= prio_load.level;
    end else if (wr_en && awaddr_q == OFF_PRIO && wmask_q[PRIO_LSB] &&
                 !gctl_q[BIT_NEST]) begin
      prio_q <= wdata_q[PRIO_LSB+2:PRIO_LSB]; // RL21
    end
  end

  // View for the core, registered from the current register state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_view_q <= '0;
    end else begin
      core_view_q.level           <= {pl_msb_q, prio_q}; // RL2
      core_view_q.user_blocked    <= (prio_q == PRIO_ALL1); // RL20
      core_view_q.nesting_disable <= gctl_q[BIT_NEST]; // RL6
      core_view_q.alt_vector      <= evctl_q[BIT_ALTV]; // RL11
    end
  end

  // Read multiplexer; unmapped addresses answer an error with zero data.
  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      OFF_CORE: begin
        rd_val[BIT_PL_MSB] = pl_msb_q;
        rd_val[BIT_VIS]    = vis_q; // RL4
      end
      OFF_GCTL:  rd_val = gctl_q;
      OFF_EVCTL: rd_val = evctl_q;
      OFF_FLO:   rd_val = flo_q;
      OFF_FNX:   rd_val = fnx_q;
      OFF_PRIO:  rd_val[PRIO_LSB+2:PRIO_LSB] = prio_q;
      default:   rd_ok = 1'b0;
    endcase
  end

  // Read channel: data one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {16'h0000, rd_val}; // RL5
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Checks on the register behaviour.
  chk_msb_set_wins: assert property ( // RL1
    @(posedge aclk) disable iff (!aresetn)
    core_msb_set |=> pl_msb_q ##1 core_view_q.level[3])
    else $error("priority msb not set by core");

  chk_msb_no_sw_set: assert property ( // RL3
    @(posedge aclk) disable iff (!aresetn)
    (!pl_msb_q && !core_msb_set) |=> !pl_msb_q)
    else $error("priority msb rose without core set");

  chk_level_concat: assert property ( // RL2
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> core_view_q.level == {$past(pl_msb_q), $past(prio_q)})
    else $error("core level not msb over priority field");

  chk_user_block: assert property ( // RL20
    @(posedge aclk) disable iff (!aresetn)
    (prio_q == PRIO_ALL1) |=> core_view_q.user_blocked)
    else $error("user interrupts not blocked at top priority");

  chk_prio_locked: assert property ( // RL21
    @(posedge aclk) disable iff (!aresetn)
    (gctl_q[BIT_NEST] && !prio_load.load) |=> $stable(prio_q))
    else $error("priority field changed while nesting disabled");

  chk_trap_arith: assert property ( // RL7
    @(posedge aclk) disable iff (!aresetn)
    trap_evt.arith |=> gctl_q[BIT_ARITH])
    else $error("arithmetic trap not recorded");

  chk_trap_stack: assert property ( // RL9
    @(posedge aclk) disable iff (!aresetn)
    trap_evt.stack |=> gctl_q[BIT_STACK])
    else $error("stack trap not recorded");

  chk_ext_flag: assert property ( // RL22
    @(posedge aclk) disable iff (!aresetn)
    ext_edge_q[0] |=> flo_q[EXT0_BIT])
    else $error("external edge did not set its flag");

  chk_flag_holds: assert property ( // RL19
    @(posedge aclk) disable iff (!aresetn)
    (flo_q[3] && !(wr_en && awaddr_q == OFF_FLO)) |=> flo_q[3])
    else $error("request flag cleared without software");

  chk_unimpl_zero: assert property ( // RL5
    @(posedge aclk) disable iff (!aresetn)
    ((gctl_q & ~MASK_GCTL) == 16'h0000) && ((flo_q & ~MASK_FLO) == 16'h0000)
    && ((fnx_q & ~MASK_FNX) == 16'h0000))
    else $error("unimplemented bit holds a one");

  chk_block_track: assert property ( // RL12
    @(posedge aclk) disable iff (!aresetn)
    timed_block_in |=> evctl_q[BIT_TBLK])
    else $error("timed block status not shown");

endmodule

/* File: tb/icf_src_model.sv */
/*
  Behavioural model of the core and the peripheral sources that face the
  flag block: trap, priority and source pulses, and slow pin levels.
  Assumes aclk is the block clock; every change follows a rising edge.
*/
`timescale 1ns/10ps
module icf_src_model
  import icf_pkg::*;
(
  input  wire logic    aclk,
  output icf_trap_t    trap_evt,
  output logic         core_msb_set,
  output icf_prio_load_t prio_load,
  output logic         vis,
  output logic         timed_block,
  output logic [15:0]  evt_low,
  output logic [15:0]  evt_next,
  output logic [4:0]   pins
);
  // Quiet pulses and levels from time zero.
  initial begin
    trap_evt     = '0;
    core_msb_set = 1'b0;
    prio_load    = '0;
    vis          = 1'b1;
    timed_block  = 1'b0;
    evt_low      = 16'h0000;
    evt_next     = 16'h0000;
    pins         = 5'h00;
  end

  // One-cycle event pulses; sources only ever set flags.
  task automatic pulse(input icf_trap_t t, input logic m,
                       input icf_prio_load_t p, input logic [15:0] lo,
                       input logic [15:0] hi);
    @(posedge aclk);
    trap_evt     <= t;
    core_msb_set <= m;
    prio_load    <= p;
    evt_low      <= lo;
    evt_next     <= hi;
    @(posedge aclk);
    trap_evt     <= '0;
    core_msb_set <= 1'b0;
    prio_load    <= '0;
    evt_low      <= 16'h0000;
    evt_next     <= 16'h0000;
  endtask

  // Slow levels: visibility, timed block and the external pins.
  task automatic set_lvl(input logic v, input logic b, input logic [4:0] q);
    @(posedge aclk);
    vis         <= v;
    timed_block <= b;
    pins        <= q;
  endtask
endmodule

/* File: tb/tb_top.sv */
/*
  Self-checking bench for the interrupt flag block: AXI4-Lite register
  tasks, a source model, and sequences of register calls with expectations.
  Assumes the block answers each bus request within a few cycles.
*/
`timescale 1ns/10ps
module tb_top;
  import icf_pkg::*;
  logic           aclk, aresetn;
  logic [7:0]     s_axi_awaddr, s_axi_araddr;
  logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0]    s_axi_wdata, s_axi_rdata;
  logic [3:0]     s_axi_wstrb;
  logic [1:0]     s_axi_bresp, s_axi_rresp;
  logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic           s_axi_rvalid, s_axi_rready, core_msb_set, vis, tblk;
  icf_trap_t      trap_evt;
  icf_prio_load_t prio_load;
  logic [15:0]    evt_low, evt_next;
  logic [4:0]     pins, ext_edge_q;
  icf_core_view_t core_view_q;
  int             errors, tests_run, n;

  icf_src_model u_src (.aclk(aclk), .trap_evt(trap_evt),
    .core_msb_set(core_msb_set), .prio_load(prio_load), .vis(vis),
    .timed_block(tblk), .evt_low(evt_low), .evt_next(evt_next),
    .pins(pins));

  icf_top u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .trap_evt(trap_evt),
    .core_msb_set(core_msb_set), .prio_load(prio_load),
    .program_space_visibility(vis), .timed_block_in(tblk),
    .src_evt_low(evt_low), .src_evt_next(evt_next),
    .ext_irq_pin(pins), .core_view_q(core_view_q),
    .ext_edge_q(ext_edge_q));

  // Free-running 200 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("Counts: errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A limit that runs out counts a mismatch and ends the run.
  task automatic expire;
    errors++;
    $display("BAD t=%0t wait limit ran out", $time);
    test_done();
  endtask

  // Expected response: offsets past the last register are refused.
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a > OFF_PRIO) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  // Write with address and data offered together, each held until taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 40) expire();
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, resp_of(a)});
  endtask

  // Read one register and compare data and response.
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 40) expire();
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, {16'h0000, e});
    check({30'h0, s_axi_rresp}, {30'h0, resp_of(a)});
  endtask

  // Waits for an edge pulse on one pin, then lets the flag land.
  task automatic wait_edge(input int k);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (ext_edge_q[k] === 1'b1) break;
    end
    if (n == 40) expire();
    repeat (2) @(posedge aclk);
  endtask

  // Main sequence of register calls.
  initial begin
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_CORE, 16'h0004);
    rchk(OFF_GCTL, 16'h0000);
    rchk(OFF_EVCTL, 16'h0000);
    rchk(OFF_FLO, 16'h0000);
    rchk(OFF_FNX, 16'h0000);
    rchk(OFF_PRIO, 16'h0000);
    // Unmapped place is refused and reads zero.
    wr(8'h18, 16'hFFFF);
    rchk(8'h18, 16'h0000);
    wr(OFF_GCTL, 16'hFFFF);
    rchk(OFF_GCTL, 16'h801E);
    check({31'h0, core_view_q.nesting_disable}, 32'h1);
    // Each trap sets only its own status bit.
    for (int i = 0; i < 4; i++) begin
      wr(OFF_GCTL, 16'h0000);
      u_src.pulse(icf_trap_t'(4'h8 >> i), 1'b0, '0, 16'h0, 16'h0);
      rchk(OFF_GCTL, 16'h0010 >> i);
    end
    wr(OFF_EVCTL, 16'hFFFF);
    rchk(OFF_EVCTL, 16'h801F);
    check({31'h0, core_view_q.alt_vector}, 32'h1);
    u_src.set_lvl(1'b0, 1'b1, 5'h00);
    rchk(OFF_EVCTL, 16'hC01F);
    rchk(OFF_CORE, 16'h0000);
    u_src.set_lvl(1'b1, 1'b0, 5'h00);
    wr(OFF_EVCTL, 16'h0000);
    // The core view lags the registers by one clock.
    @(posedge aclk);
    check({31'h0, core_view_q.alt_vector}, 32'h0);
    // Every source pulsed at once; unimplemented places stay zero.
    u_src.pulse('0, 1'b0, '0, 16'hFFFF, 16'hFFFF);
    rchk(OFF_FLO, 16'h7FFF);
    rchk(OFF_FNX, 16'hFF1F);
    rchk(OFF_FNX, 16'hFF1F);
    wr(OFF_FLO, 16'h0000);
    wr(OFF_FNX, 16'h0000);
    rchk(OFF_FLO, 16'h0000);
    rchk(OFF_FNX, 16'h0000);
    // Priority field, its msb and the user block.
    wr(OFF_PRIO, 16'h00E0);
    rchk(OFF_PRIO, 16'h00E0);
    check({25'h0, core_view_q}, {25'h0, 4'h7, 3'b100});
    u_src.pulse('0, 1'b1, '0, 16'h0, 16'h0);
    rchk(OFF_CORE, 16'h000C);
    check({28'h0, core_view_q.level}, 32'hF);
    wr(OFF_CORE, 16'hFFFF);
    rchk(OFF_CORE, 16'h000C);
    wr(OFF_CORE, 16'h0000);
    rchk(OFF_CORE, 16'h0004);
    wr(OFF_PRIO, 16'h0040);
    @(posedge aclk);
    check({25'h0, core_view_q}, {25'h0, 4'h2, 3'b000});
    // While nesting is off only the core may move the field.
    wr(OFF_GCTL, 16'h8000);
    wr(OFF_PRIO, 16'h00A0);
    rchk(OFF_PRIO, 16'h0040);
    u_src.pulse('0, 1'b0, {1'b1, 3'h5}, 16'h0, 16'h0);
    rchk(OFF_PRIO, 16'h00A0);
    wr(OFF_GCTL, 16'h0000);
    // Pins 1 and 3 watch falling edges, the others rising ones.
    wr(OFF_EVCTL, 16'h000A);
    u_src.set_lvl(1'b1, 1'b0, 5'b11111);
    wait_edge(4);
    rchk(OFF_FLO, 16'h0001);
    rchk(OFF_FNX, 16'h2000);
    u_src.set_lvl(1'b1, 1'b0, 5'b10000);
    wait_edge(3);
    rchk(OFF_FLO, 16'h0001);
    rchk(OFF_FNX, 16'h2010);
    test_done();
  end
endmodule
